// >>> core/gpio_pin_config_16_to_31.sv
`timescale 1ns/1ps
`include "gpio_cfg_consts.svh"
module gpio_pin_config_16_to_31
	import gpio_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] outValue,
	input wire logic [15:0] tristateEnable,
	input wire logic [15:0] padIn,
	output logic [15:0] padOut,
	output logic [15:0] padOen_n,
	output logic [15:0] pinLevel,
	output logic [15:0] edgeIrq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [31:0] cfgLow, cfgHigh, pad_write_unlock_key, readData;
	logic [31:0] next_cfgLow, next_cfgHigh, next_pad_write_unlock_key, next_readData;
	logic [15:0] readLevel, cellOut, cellOen_n;
	logic unlocked, wrEn, rdEn;
	apb_req_t req;

	// offset match helper
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction

	assign req = '{paddr: paddr, pwrite: pwrite, psel: psel, penable: penable, pwdata: pwdata};
	assign unlocked = (pad_write_unlock_key == `PAD_KEY_UNLOCK_VAL);
	assign wrEn = req.psel & req.penable & req.pwrite;
	assign rdEn = req.psel & ~req.penable & ~req.pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = readData;

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_comb begin
		next_cfgLow = cfgLow;
		next_cfgHigh = cfgHigh;
		next_pad_write_unlock_key = pad_write_unlock_key;
		if (wrEn && hit(req.paddr, `PAD_KEY_OFS)) begin
			next_pad_write_unlock_key = req.pwdata;
		end
		if (wrEn && unlocked && hit(req.paddr, `CFG_WORD_16_23_OFS)) begin
			next_cfgLow = req.pwdata;
		end
		if (wrEn && unlocked && hit(req.paddr, `CFG_WORD_24_31_OFS)) begin
			next_cfgHigh = req.pwdata;
		end
	end

	// read data captured in setup phase, unmapped reads zero
	always_comb begin
		next_readData = readData;
		if (rdEn) begin
			if (hit(req.paddr, `CFG_WORD_16_23_OFS)) begin
				next_readData = cfgLow;
			end else if (hit(req.paddr, `CFG_WORD_24_31_OFS)) begin
				next_readData = cfgHigh;
			end else if (hit(req.paddr, `PAD_KEY_OFS)) begin
				next_readData = {31'h00000000, unlocked};
			end else begin
				next_readData = 32'h00000000;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfgLow <= `CFG_WORD_16_23_RST;
			cfgHigh <= `CFG_WORD_24_31_RST;
			pad_write_unlock_key <= 32'h00000000;
			readData <= 32'h00000000;
		end else begin
			cfgLow <= next_cfgLow;
			cfgHigh <= next_cfgHigh;
			pad_write_unlock_key <= next_pad_write_unlock_key;
			readData <= next_readData;
		end
	end

	// ----------------------------------------
	// per-pin cells
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 16; i = i + 1) begin : gPin
			pin_slot_t slot;
			// lowest pin in lowest slot
			if (i < 8) begin : gLow
				assign slot = cfgLow[i*`SLOT_WIDTH +: `SLOT_WIDTH];
			end else begin : gHigh
				assign slot = cfgHigh[(i-8)*`SLOT_WIDTH +: `SLOT_WIDTH];
			end
			gpio_pin_cell uCell (
				.clk(clk),
				.nrst(nrst),
				.slot(slot),
				.outValue(outValue[i]),
				.padIn(padIn[i]),
				.padOut(cellOut[i]),
				.padOen_n(cellOen_n[i]),
				.readLevel(readLevel[i]),
				.edgeIrq(edgeIrq[i])
			);
			// high impedance mode releases pin when asked
			assign padOut[i] = cellOut[i];
			assign padOen_n[i] = cellOen_n[i] |
				((slot.outputDriveSelect == high_impedance_drive) & tristateEnable[i]);
			assign pinLevel[i] = readLevel[i];
		end
	endgenerate
endmodule

// >>> core/gpio_cfg_consts.svh
`ifndef GPIO_CFG_CONSTS_SVH
`define GPIO_CFG_CONSTS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define CFG_WORD_16_23_OFS 12'h048
`define CFG_WORD_24_31_OFS 12'h04c
`define PAD_KEY_OFS 12'h060
`define PAD_KEY_UNLOCK_VAL 32'h00000073
// ----------------------------------------
// field layout inside a slot
// ----------------------------------------
`define SLOT_WIDTH 4
`define SLOT_POL_BIT 3
`define SLOT_DRV_LSB 1
`define SLOT_RD_BIT 0
// ----------------------------------------
// reset values
// ----------------------------------------
`define CFG_WORD_16_23_RST 32'h00110000
`define CFG_WORD_24_31_RST 32'h00000000
`endif

// >>> core/gpio_cfg_pkg.sv
package gpio_cfg_pkg;
	typedef enum logic [1:0] {
		output_off = 2'h0,
		totem_drive = 2'h1,
		open_drain_drive = 2'h2,
		high_impedance_drive = 2'h3
	} output_drive_select_t;
	typedef struct packed {
		logic edgePolaritySelect;
		output_drive_select_t outputDriveSelect;
		logic inputReadSelect;
	} pin_slot_t;
	typedef struct packed {
		logic [11:0] paddr;
		logic pwrite;
		logic psel;
		logic penable;
		logic [31:0] pwdata;
	} apb_req_t;
endpackage

// >>> core/gpio_pin_cell.sv
`timescale 1ns/1ps
`include "gpio_cfg_consts.svh"
module gpio_pin_cell
	import gpio_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire pin_slot_t slot,
	input wire logic outValue,
	input wire logic padIn,
	output logic padOut,
	output logic padOen_n,
	output logic readLevel,
	output logic edgeIrq
);
	logic syncA, syncB, prevLevel;
	logic next_syncA, next_syncB, next_prevLevel;
	// history is trusted only once all three stages hold post-reset samples
	logic [2:0] histValid, next_histValid;

	// two-flop synchroniser and edge history
	always_comb begin
		next_syncA = padIn;
		next_syncB = syncA;
		next_prevLevel = syncB;
		next_histValid = {histValid[1:0], 1'b1};
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
			prevLevel <= 1'b0;
			histValid <= 3'h0;
		end else begin
			syncA <= next_syncA;
			syncB <= next_syncB;
			prevLevel <= next_prevLevel;
			histValid <= next_histValid;
		end
	end

	// rising or falling edge chosen by polarity, masked while reset zeros fill the history
	// so a pin idling high gives no false edge after reset
	assign edgeIrq = histValid[2] &
		(slot.edgePolaritySelect ? (prevLevel & ~syncB) : (~prevLevel & syncB));
	// read select forces zero
	assign readLevel = slot.inputReadSelect ? 1'b0 : syncB;

	// drive mode decode, enable low means driving
	always_comb begin
		padOut = 1'b0;
		padOen_n = 1'b1;
		case (slot.outputDriveSelect)
			output_off: begin
				padOen_n = 1'b1;
			end
			totem_drive: begin
				padOut = outValue;
				padOen_n = 1'b0;
			end
			open_drain_drive: begin
				padOut = 1'b0;
				padOen_n = outValue;
			end
			high_impedance_drive: begin
				padOut = outValue;
				padOen_n = 1'b0;
			end
			default: begin
				padOen_n = 1'b1;
			end
		endcase
	end
endmodule

// >>> verif/gpio_cfg_assertions.sv
`timescale 1ns/1ps
module gpio_cfg_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] outValue,
	input wire logic [15:0] tristateEnable,
	input wire logic [15:0] padIn,
	input wire logic [15:0] padOut,
	input wire logic [15:0] padOen_n,
	input wire logic [15:0] pinLevel,
	input wire logic [15:0] edgeIrq
);
	logic key;
	logic [63:0] cfg;
	// shadow key and words from taken writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			key <= 1'h0;
			cfg <= 64'h0000000000110000;
		end else if (psel && penable && pwrite) begin
			if (paddr == 12'h060) key <= pwdata == 32'h00000073;
			if (key && paddr == 12'h048) cfg[31:0] <= pwdata;
			if (key && paddr == 12'h04c) cfg[63:32] <= pwdata;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// per-pin slot checks
	for (genvar i = 0; i < 16; i++) begin : pin
		wire logic [3:0] s = cfg[4*i+:4];
		chk_rd_zero: assert property (s[0] && $past(s[0]) |-> !pinLevel[i])
			else $error("level not zero");
		chk_drive_off: assert property (s[2:1] == 2'h0 |-> padOen_n[i])
			else $error("off pin driven");
		chk_drive_push: assert property (s[2:1] == 2'h1
			|-> !padOen_n[i] && padOut[i] == outValue[i])
			else $error("push drive wrong");
		chk_drive_od: assert property (s[2:1] == 2'h2 |-> padOen_n[i] == outValue[i])
			else $error("drain drive wrong");
		chk_drive_ts: assert property (s[2:1] == 2'h3 |-> padOen_n[i] == tristateEnable[i])
			else $error("tristate wrong");
		chk_edge_dir: assert property (edgeIrq[i] |-> $past(padIn[i], 2) != s[3])
			else $error("wrong edge");
		chk_irq_pulse: assert property (edgeIrq[i] |=> !edgeIrq[i])
			else $error("pulse too long");
	end
	chk_read_word: assert property (psel && penable && !pwrite && paddr[11:3] == 9'h009
		|-> prdata == (paddr[2] ? cfg[63:32] : cfg[31:0]))
		else $error("read data wrong");
	cov_open: cover property (key && psel && penable && pwrite);
	cov_shut: cover property (!key && psel && penable && pwrite && paddr == 12'h048);
	cov_irq: cover property (edgeIrq[8]);
endmodule
bind gpio_pin_config_16_to_31 gpio_cfg_checker u_chk (
	.clk(clk),
	.nrst(nrst),
	.paddr(paddr),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.outValue(outValue),
	.tristateEnable(tristateEnable),
	.padIn(padIn),
	.padOut(padOut),
	.padOen_n(padOen_n),
	.pinLevel(pinLevel),
	.edgeIrq(edgeIrq)
);

// >>> verif/gpio_pad_model.sv
`timescale 1ns/1ps
module gpio_pad_model (
	input wire logic [15:0] padOut,
	input wire logic [15:0] padOen_n,
	input wire logic [15:0] extLevel,
	output logic [15:0] padIn
);
	// driven pin shows device value, released pin the outside level
	assign padIn = (padOut & ~padOen_n) | (extLevel & padOen_n);
endmodule

// >>> verif/gpio_pin_config_16_to_31_tb.sv
`timescale 1ns/1ps
module gpio_pin_config_16_to_31_tb;
	logic clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [15:0] outValue = 16'h0, tristateEnable = 16'h0, extLevel = 16'h0;
	logic [15:0] padIn, padOut, padOen_n, pinLevel, edgeIrq, seen;
	int err_total = 0, total_checks = 0, cyc = 0;
	// address, write data, expected read
	logic [75:0] rows [3] = '{76'h0487654321076543210, 76'h04cfedcba98fedcba98,
		76'h0501234567800000000};
	gpio_pin_config_16_to_31 DUT (
		.clk(clk),
		.nrst(nrst),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.outValue(outValue),
		.tristateEnable(tristateEnable),
		.padIn(padIn),
		.padOut(padOut),
		.padOen_n(padOen_n),
		.pinLevel(pinLevel),
		.edgeIrq(edgeIrq)
	);
	gpio_pad_model pads (
		.padOut(padOut),
		.padOen_n(padOen_n),
		.extLevel(extLevel),
		.padIn(padIn)
	);
	always #4 clk = ~clk;
	// -----------------
	// tasks
	// -----------------
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		r = prdata;
		chk({31'h0, pslverr}, 32'h0);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task win;
		seen = 16'h0;
		repeat (6) begin
			@(negedge clk);
			seen = seen | edgeIrq;
		end
		@(posedge clk);
	endtask
	task final_report;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			final_report;
		end
	end
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'h1;
		extLevel <= 16'hffff;
		repeat (5) @(posedge clk);
		chk({16'h0, pinLevel}, 32'h0000ffcf);
		apb(1'h0, 12'h048, 32'h0);
		chk(r, 32'h00110000);
		apb(1'h0, 12'h04c, 32'h0);
		chk(r, 32'h0);
		apb(1'h1, 12'h048, 32'hffffffff);
		apb(1'h0, 12'h048, 32'h0);
		chk(r, 32'h00110000);
		apb(1'h1, 12'h060, 32'h00000073);
		foreach (rows[k]) begin
			apb(1'h1, rows[k][75:64], rows[k][63:32]);
			apb(1'h0, rows[k][75:64], 32'h0);
			chk(r, rows[k][31:0]);
			repeat (2) begin
				extLevel <= ~extLevel;
				outValue <= ~outValue;
				tristateEnable <= ~tristateEnable;
				repeat (6) @(posedge clk);
			end
		end
		apb(1'h1, 12'h04c, 32'h88888888);
		apb(1'h1, 12'h048, 32'h0);
		extLevel <= 16'h0;
		repeat (6) @(posedge clk);
		extLevel <= 16'hffff;
		win;
		chk({16'h0, seen}, 32'h000000ff);
		extLevel <= 16'h0;
		win;
		chk({16'h0, seen}, 32'h0000ff00);
		apb(1'h1, 12'h060, 32'h0);
		apb(1'h1, 12'h04c, 32'h0);
		apb(1'h0, 12'h04c, 32'h0);
		chk(r, 32'h88888888);
		// mid-run reset: words return to reset values and the key locks again
		nrst <= 1'h0;
		extLevel <= 16'hffff;
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		repeat (3) @(posedge clk);
		chk({16'h0, pinLevel}, 32'h0000ffcf);
		apb(1'h1, 12'h04c, 32'hffffffff);
		apb(1'h0, 12'h04c, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, 12'h048, 32'h0);
		chk(r, 32'h00110000);
		final_report;
	end
endmodule
